// File: pkg/rsw_pkg.sv
package rsw_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  // low-supply release delay in ms
  localparam int SUPPLY_HOLD_MS = 10;
  // ms to clock cycles, 500000 at 50 MHz
  localparam int SUPPLY_HOLD_CYCLES = SUPPLY_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  // oscillator periods per machine cycle
  localparam int MCYC_OSC = 12;
  localparam logic [3:0] MCYC_LAST = 4'(MCYC_OSC - 1);
  // watchdog reset pulse is 12 x 2^15 oscillator periods
  localparam int DOG_PULSE_EXP = 15;
  localparam int DOG_PULSE_CYCLES = MCYC_OSC * (2 ** DOG_PULSE_EXP);
  // restart delay in machine cycles
  localparam int RESTART_MCYC = 3;
  // consecutive se0 samples for a bus reset
  localparam logic [2:0] SE0_MIN_COUNT = 3'h4;

  // stretcher counter width, holds the larger count
  localparam int STRETCH_W = 20;
  typedef logic [STRETCH_W-1:0] rsw_count_type;

  // watchdog counter
  localparam int DOG_WIDTH = 22;
  localparam int DOG_RELOAD_BITS = 7;
  localparam logic [21:0] DOG_MAX = 22'h3fffff;
  localparam logic [21:0] DOG_CLEAR = 22'h000000;
  localparam logic [14:0] DOG_LOW_CLEAR = 15'h0000;
  localparam logic [7:0] DOG_KEY_DISABLE = 8'h55;
  localparam logic [7:0] DOG_KEY_RESET = 8'h00;

  // printed register indices, byte address is four times
  localparam logic [7:0] IDX_RELOAD = 8'ha6;
  localparam logic [7:0] IDX_KEY = 8'hae;
  localparam logic [11:0] ADDR_RELOAD = {2'h0, IDX_RELOAD, 2'h0};
  localparam logic [11:0] ADDR_KEY = {2'h0, IDX_KEY, 2'h0};
  // control and status words
  localparam logic [11:0] ADDR_PWR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_USB_STA = 12'h004;
  localparam logic [11:0] ADDR_USB_EN = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;

  // field positions
  localparam int PWR_SUPPLY_EN_BIT = 0;
  localparam int USB_RST_FLAG_BIT = 6;
  localparam int USB_RST_EN_BIT = 6;
  localparam int STAT_DOG_EN_BIT = 24;
  localparam int STAT_CORE_RST_BIT = 25;

  // values after reset
  localparam logic SUPPLY_EN_RESET = 1'b1;
  localparam logic USB_EN_RESET = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // write channel states, one-hot
  typedef enum logic [2:0] {
    RSW_WR_COLLECT = 3'b001,
    RSW_WR_COMMIT = 3'b010,
    RSW_WR_RESP = 3'b100
  } rsw_wr_state_type;
endpackage : rsw_pkg

// File: pkg/rsw_evt_if.sv
`timescale 1ns/1ps
// level in, tick in, registered result out
interface rsw_evt_if;
  logic level;
  logic tick;
  logic result;
  // user drives level and tick
  modport user (output level, output tick, input result);
  // unit produces result
  modport unit (input level, input tick, output result);
endinterface : rsw_evt_if

// File: hdl/rsw_stretch.sv
`timescale 1ns/1ps
// holds result for HOLD ticks after level drops
module rsw_stretch #(
  parameter rsw_pkg::rsw_count_type HOLD = 20'h00001,
  parameter logic START = 1'b0
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  rsw_evt_if.unit evt
);
  typedef struct packed {
    rsw_pkg::rsw_count_type cnt;
    logic held;
  } rsw_stretch_state_type;

  rsw_stretch_state_type state_q;
  rsw_stretch_state_type state_d;

  // reload while level, count down on tick
  always_comb begin
    state_d = state_q;
    if (evt.level) begin
      state_d.cnt = HOLD;
    end else if (evt.tick && state_q.cnt != '0) begin
      state_d.cnt = state_q.cnt - 1'b1;
    end
    // result lags level by one edge, from a flop
    state_d.held = (state_d.cnt != '0);
  end

  // START lets a stretcher come out of reset asserted
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q.cnt <= START ? HOLD : '0;
      state_q.held <= START;
    end else begin
      state_q <= state_d;
    end
  end

  assign evt.result = state_q.held;
endmodule : rsw_stretch

// File: hdl/rsw_se0_count.sv
`timescale 1ns/1ps
// flags a bus reset after enough consecutive se0 ticks
module rsw_se0_count (
  input wire logic mclk_in,
  input wire logic srst_in,
  rsw_evt_if.unit evt
);
  typedef struct packed {
    logic [2:0] cnt;
    logic hit;
  } rsw_se0_state_type;

  rsw_se0_state_type state_q;
  rsw_se0_state_type state_d;

  // any gap in se0 restarts the count, saturates at the limit
  always_comb begin
    state_d = state_q;
    if (!evt.level) begin
      state_d.cnt = 3'h0;
    end else if (evt.tick && state_q.cnt < rsw_pkg::SE0_MIN_COUNT) begin
      state_d.cnt = state_q.cnt + 3'h1;
    end
    state_d.hit = evt.level && (state_d.cnt >= rsw_pkg::SE0_MIN_COUNT);
  end

  // plain state register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign evt.result = state_q.hit;
endmodule : rsw_se0_count

// File: hdl/rsw_top.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Functional notes
// - any of four sources asserts core reset
// - core reset also drives memory reset_n
// - low-supply reset lingers 10ms after recovery
// - low-supply reset on by default, clearable
// - low-supply reset works in every mode
// - repeated se0 sets the bus-reset flag
// - enabled bus reset also resets the core
// - 22-bit counter counts machine cycles
// - counter overflow causes internal reset
// - watchdog enabled after power-up and reset
// - reload value fills the seven top bits
// - writing zero clears the whole counter
// - only key 55h stops the watchdog
// - watchdog keeps running during idle
// - watchdog pulse lasts 12 x 2^15 periods
// - core restarts three machine cycles after release
module rsw_top #(
  parameter int SUPPLY_HOLD_CYC = rsw_pkg::SUPPLY_HOLD_CYCLES,
  parameter int DOG_PULSE_CYC = rsw_pkg::DOG_PULSE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [11:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [11:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic ext_reset_n_in,
  input wire logic supply_low_in,
  input wire logic usb_se0_in,
  output logic core_reset_out,
  output logic mem_reset_n_out
);
  typedef struct packed {
    rsw_pkg::rsw_wr_state_type wr_state;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_strb0;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] mcyc_cnt;
    logic mcyc_tick;
    logic [21:0] dog_cnt;
    logic dog_ovf;
    logic [7:0] key;
    logic supply_en;
    logic usb_flag;
    logic usb_en;
    logic usb_det_d;
  } rsw_top_state_type;

  rsw_top_state_type state_q;
  rsw_top_state_type state_d;

  // bus handshake terms
  logic aw_take;
  logic w_take;
  logic ar_take;
  // write decode strobes, valid only in commit
  logic wr_ok;
  logic pwr_wr;
  logic sta_wr;
  logic en_wr;
  logic reload_wr;
  logic key_wr;
  // read mux result
  logic [31:0] rd_data;
  logic rd_ok;
  // derived status
  logic dog_enabled;
  logic core_rst;

  // one channel per reset source except the pin, plus the restart delay
  rsw_evt_if supply_if ();
  rsw_evt_if dog_if ();
  rsw_evt_if usb_if ();
  rsw_evt_if rst_if ();

  assign supply_if.level = supply_low_in && state_q.supply_en;
  assign supply_if.tick = 1'b1;
  // overflow is a one-cycle pulse, stretcher widens it
  assign dog_if.level = state_q.dog_ovf;
  assign dog_if.tick = 1'b1;
  // se0 is counted in machine cycles
  assign usb_if.level = usb_se0_in;
  assign usb_if.tick = state_q.mcyc_tick;
  assign rst_if.level = !ext_reset_n_in || supply_if.result ||
                        (usb_if.result && state_q.usb_en) || dog_if.result;
  assign rst_if.tick = state_q.mcyc_tick;

  // no mode input gates this path
  rsw_stretch #(
    .HOLD(rsw_pkg::rsw_count_type'(SUPPLY_HOLD_CYC)),
    .START(1'b0)
  ) u_supply_hold (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .evt(supply_if.unit)
  );

  // pulse of 12 x 2^15 clock periods
  rsw_stretch #(
    .HOLD(rsw_pkg::rsw_count_type'(DOG_PULSE_CYC)),
    .START(1'b0)
  ) u_dog_pulse (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .evt(dog_if.unit)
  );

  rsw_se0_count u_se0 (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .evt(usb_if.unit)
  );

  // three machine cycles after release
  // starts asserted so the core waits after power-up
  rsw_stretch #(
    .HOLD(rsw_pkg::rsw_count_type'(rsw_pkg::RESTART_MCYC)),
    .START(1'b1)
  ) u_restart (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .evt(rst_if.unit)
  );

  assign core_rst = rst_if.result;
  assign dog_enabled = (state_q.key != rsw_pkg::DOG_KEY_DISABLE);

  // outputs: handshakes combinational, data from flops
  assign awready_out = (state_q.wr_state == rsw_pkg::RSW_WR_COLLECT) && !state_q.aw_held;
  assign wready_out = (state_q.wr_state == rsw_pkg::RSW_WR_COLLECT) && !state_q.w_held;
  assign bvalid_out = (state_q.wr_state == rsw_pkg::RSW_WR_RESP);
  assign bresp_out = state_q.bresp;
  assign arready_out = !state_q.rvalid;
  assign rvalid_out = state_q.rvalid;
  assign rdata_out = state_q.rdata;
  assign rresp_out = state_q.rresp;
  assign core_reset_out = core_rst;
  assign mem_reset_n_out = !core_rst;

  assign aw_take = awvalid_in && awready_out;
  assign w_take = wvalid_in && wready_out;
  assign ar_take = arvalid_in && arready_out;

  // read mux, decoded straight from the request address
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (araddr_in)
      rsw_pkg::ADDR_PWR_CTRL: begin
        rd_data = 32'(state_q.supply_en) << rsw_pkg::PWR_SUPPLY_EN_BIT;
      end
      rsw_pkg::ADDR_USB_STA: begin
        rd_data = 32'(state_q.usb_flag) << rsw_pkg::USB_RST_FLAG_BIT;
      end
      rsw_pkg::ADDR_USB_EN: begin
        rd_data = 32'(state_q.usb_en) << rsw_pkg::USB_RST_EN_BIT;
      end
      rsw_pkg::ADDR_STATUS: begin
        // live counter plus enable and reset state
        rd_data = 32'(state_q.dog_cnt) |
                  (32'(dog_enabled) << rsw_pkg::STAT_DOG_EN_BIT) |
                  (32'(core_rst) << rsw_pkg::STAT_CORE_RST_BIT);
      end
      rsw_pkg::ADDR_RELOAD: begin
        rd_data = 32'(state_q.dog_cnt[rsw_pkg::DOG_WIDTH-1 -: rsw_pkg::DOG_RELOAD_BITS]);
      end
      rsw_pkg::ADDR_KEY: begin
        rd_data = 32'(state_q.key);
      end
      default: begin
        // unmapped reads zero with an error
        rd_ok = 1'b0;
      end
    endcase
  end

  // write decode, only acts in the commit state
  always_comb begin
    wr_ok = 1'b0;
    pwr_wr = 1'b0;
    sta_wr = 1'b0;
    en_wr = 1'b0;
    reload_wr = 1'b0;
    key_wr = 1'b0;
    if (state_q.wr_state == rsw_pkg::RSW_WR_COMMIT) begin
      case (state_q.aw_addr)
        rsw_pkg::ADDR_PWR_CTRL: begin
          wr_ok = 1'b1;
          pwr_wr = state_q.w_strb0;
        end
        rsw_pkg::ADDR_USB_STA: begin
          wr_ok = 1'b1;
          sta_wr = state_q.w_strb0;
        end
        rsw_pkg::ADDR_USB_EN: begin
          wr_ok = 1'b1;
          en_wr = state_q.w_strb0;
        end
        rsw_pkg::ADDR_STATUS: begin
          // read-only, write accepted and dropped
          wr_ok = 1'b1;
        end
        rsw_pkg::ADDR_RELOAD: begin
          wr_ok = 1'b1;
          reload_wr = state_q.w_strb0;
        end
        rsw_pkg::ADDR_KEY: begin
          wr_ok = 1'b1;
          key_wr = state_q.w_strb0;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  // next state of everything the top owns
  always_comb begin
    state_d = state_q;

    // machine cycle divider, tick is one clock in twelve
    state_d.mcyc_tick = (state_q.mcyc_cnt == rsw_pkg::MCYC_LAST);
    state_d.mcyc_cnt = state_d.mcyc_tick ? 4'h0 : state_q.mcyc_cnt + 4'h1;

    // write channel: address and data in either order
    unique case (state_q.wr_state)
      rsw_pkg::RSW_WR_COLLECT: begin
        if (aw_take) begin
          state_d.aw_held = 1'b1;
          state_d.aw_addr = awaddr_in;
        end
        if (w_take) begin
          state_d.w_held = 1'b1;
          state_d.w_data = wdata_in;
          state_d.w_strb0 = wstrb_in[0];
        end
        if ((state_q.aw_held || aw_take) && (state_q.w_held || w_take)) begin
          state_d.wr_state = rsw_pkg::RSW_WR_COMMIT;
        end
      end
      rsw_pkg::RSW_WR_COMMIT: begin
        // register effects happen on this edge
        state_d.bresp = wr_ok ? rsw_pkg::RESP_OKAY : rsw_pkg::RESP_SLVERR;
        state_d.wr_state = rsw_pkg::RSW_WR_RESP;
      end
      rsw_pkg::RSW_WR_RESP: begin
        if (bready_in) begin
          state_d.aw_held = 1'b0;
          state_d.w_held = 1'b0;
          state_d.wr_state = rsw_pkg::RSW_WR_COLLECT;
        end
      end
      default: begin
        // illegal code recovers to idle
        state_d.aw_held = 1'b0;
        state_d.w_held = 1'b0;
        state_d.wr_state = rsw_pkg::RSW_WR_COLLECT;
      end
    endcase

    // read channel: one outstanding read
    if (state_q.rvalid && rready_in) begin
      state_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_data;
      state_d.rresp = rd_ok ? rsw_pkg::RESP_OKAY : rsw_pkg::RESP_SLVERR;
    end

    if (pwr_wr) begin
      state_d.supply_en = state_q.w_data[rsw_pkg::PWR_SUPPLY_EN_BIT];
    end
    if (en_wr) begin
      state_d.usb_en = state_q.w_data[rsw_pkg::USB_RST_EN_BIT];
    end

    // flag sets on detector rising edge
    // write one clears; a set in the same cycle wins
    state_d.usb_det_d = usb_if.result;
    if (sta_wr && state_q.w_data[rsw_pkg::USB_RST_FLAG_BIT]) begin
      state_d.usb_flag = 1'b0;
    end
    if (usb_if.result && !state_q.usb_det_d) begin
      state_d.usb_flag = 1'b1;
    end

    // watchdog counter
    state_d.dog_ovf = 1'b0;
    if (reload_wr) begin
      // value into the top seven bits
      // bit 7 dropped, 7fh reloads too
      state_d.dog_cnt = {state_q.w_data[rsw_pkg::DOG_RELOAD_BITS-1:0], rsw_pkg::DOG_LOW_CLEAR};
    end else if (dog_enabled && state_q.mcyc_tick) begin
      // no idle input stops this counter
      if (state_q.dog_cnt == rsw_pkg::DOG_MAX) begin
        state_d.dog_cnt = rsw_pkg::DOG_CLEAR;
        state_d.dog_ovf = 1'b1;
      end else begin
        state_d.dog_cnt = state_q.dog_cnt + 22'h000001;
      end
    end

    // key register, plain storage
    if (key_wr) begin
      state_d.key = state_q.w_data[7:0];
    end

    // key and counter cleared under reset
    if (core_rst) begin
      state_d.key = rsw_pkg::DOG_KEY_RESET;
      state_d.dog_cnt = rsw_pkg::DOG_CLEAR;
      state_d.dog_ovf = 1'b0;
    end
  end

  // single state register, bus and control defaults on reset
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= '0;
      state_q.wr_state <= rsw_pkg::RSW_WR_COLLECT;
      state_q.bresp <= rsw_pkg::RESP_OKAY;
      state_q.rresp <= rsw_pkg::RESP_OKAY;
      state_q.key <= rsw_pkg::DOG_KEY_RESET;
      state_q.supply_en <= rsw_pkg::SUPPLY_EN_RESET;
      state_q.usb_en <= rsw_pkg::USB_EN_RESET;
    end else begin
      state_q <= state_d;
    end
  end
endmodule : rsw_top

// File: verif/rsw_assertions.sv
`timescale 1ns/1ps
// watches the top ports only
module rsw_assertions (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [1:0] bresp_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic ext_reset_n_in,
  input wire logic core_reset_out,
  input wire logic mem_reset_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  a_mem_reset_inverse: assert property (mem_reset_n_out == !core_reset_out)
    else $error("memory reset is not the inverse of core reset");
  a_pin_sets_core: assert property (!ext_reset_n_in |=> core_reset_out)
    else $error("pin reset did not raise core reset");
  a_srst_holds_core: assert property ($fell(srst_in) |-> core_reset_out [*8])
    else $error("core reset released too early after reset");
  a_restart_min: assert property ($rose(ext_reset_n_in) |-> core_reset_out [*8])
    else $error("core restarted too soon after pin release");
  // one commit cycle before the answer
  a_write_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out
    |=> !bvalid_out ##1 bvalid_out)
    else $error("write response not two cycles after accept");
  a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read data not one cycle after accept");
  a_read_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped before rready");
  a_write_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped before bready");
  a_read_busy: assert property (rvalid_out |-> !arready_out)
    else $error("read address accepted while data pending");
  // main scenarios reached
  c_pin_release: cover property ($rose(ext_reset_n_in));
  c_core_release: cover property ($fell(core_reset_out));
  c_write_done: cover property (bvalid_out && bready_in);
  c_read_done: cover property (rvalid_out && rready_in);
endmodule : rsw_assertions

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic ext_n = 1'b0; // pin held low through power-up
  logic low = 1'b0;
  logic se0 = 1'b0;
  logic awr, wrdy, bv, arr, rv, crst, mrst_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, last;
  logic [1:0] ok = rsw_pkg::RESP_OKAY;
  logic [1:0] err = rsw_pkg::RESP_SLVERR;
  int failures = 0;
  int compares = 0;
  // small counts keep the run short
  rsw_top #(.SUPPLY_HOLD_CYC(20), .DOG_PULSE_CYC(30)) uut (
    .mclk_in(mclk_in), .srst_in(srst_in), .awaddr_in(awa), .awvalid_in(awv),
    .awready_out(awr), .wdata_in(wd), .wstrb_in(ws), .wvalid_in(wv), .wready_out(wrdy),
    .bresp_out(bresp), .bvalid_out(bv), .bready_in(br), .araddr_in(ara), .arvalid_in(arv),
    .arready_out(arr), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rv), .rready_in(rr),
    .ext_reset_n_in(ext_n), .supply_low_in(low), .usb_se0_in(se0),
    .core_reset_out(crst), .mem_reset_n_out(mrst_n));
  always #10 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta;
    logic tw;
    @(posedge mclk_in);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    @(negedge mclk_in);
    while (awv || wv) begin
      ta = awv && awr;
      tw = wv && wrdy;
      @(posedge mclk_in);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      @(negedge mclk_in);
    end
    while (bv !== 1'b1) @(negedge mclk_in);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge mclk_in);
    br <= 1'b0;
  endtask : wr
  // masked read compare, raw word kept in last
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex, input logic [1:0] er);
    @(posedge mclk_in);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    @(negedge mclk_in);
    while (arr !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    arv <= 1'b0;
    @(negedge mclk_in);
    while (rv !== 1'b1) @(negedge mclk_in);
    last = rdata;
    chk(rdata & m, ex);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge mclk_in);
    rr <= 1'b0;
  endtask : rd
  // core reset holds v for n cycles
  task automatic stay(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge mclk_in);
      if (crst !== v) bad++;
    end
    chk(32'(bad), 32'h0);
  endtask : stay
  // core reset reaches v within n cycles
  task automatic turn(input logic v, input int n);
    int i;
    i = 0;
    while (crst !== v && i < n) begin
      @(negedge mclk_in);
      i++;
    end
    chk({31'h0, crst}, {31'h0, v});
  endtask : turn
  task automatic end_of_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // hang guard, 1 ms power-up hold plus 10000 cycles
  initial begin
    repeat (60000) @(posedge mclk_in);
    failures++;
    end_of_test();
  end
  initial begin
    logic [7:0] keys [3];
    logic [21:0] c0;
    logic [21:0] c1;
    keys = '{8'h00, 8'h55, 8'h54};
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(negedge mclk_in);
    chk({31'h0, mrst_n}, 32'h0);
    // pin low 1ms at power-up, 50000 clocks of 20 ns
    stay(1'b1, 50000);
    @(posedge mclk_in);
    ext_n <= 1'b1;
    stay(1'b1, 8);
    turn(1'b0, 40);
    chk({31'h0, mrst_n}, 32'h1);
    rd(rsw_pkg::ADDR_PWR_CTRL, 32'hff, 32'h1, ok);
    rd(rsw_pkg::ADDR_USB_EN, 32'hff, 32'h0, ok);
    rd(rsw_pkg::ADDR_KEY, 32'hff, 32'h0, ok);
    rd(rsw_pkg::ADDR_STATUS, 32'h3000000, 32'h1000000, ok);
    // top bit of the reload value is dropped
    wr(rsw_pkg::ADDR_RELOAD, 32'h85, 4'h1, ok);
    rd(rsw_pkg::ADDR_RELOAD, 32'hff, 32'h05, ok);
    rd(rsw_pkg::ADDR_STATUS, 32'h3f8000, 32'h28000, ok);
    wr(rsw_pkg::ADDR_RELOAD, 32'h0, 4'h1, ok);
    rd(rsw_pkg::ADDR_STATUS, 32'h3fffe0, 32'h0, ok);
    wr(rsw_pkg::ADDR_RELOAD, 32'h7e, 4'h1, ok);
    rd(rsw_pkg::ADDR_RELOAD, 32'hff, 32'h7e, ok);
    // only the disable pattern stops counting
    for (int i = 0; i < 3; i++) begin
      wr(rsw_pkg::ADDR_RELOAD, 32'h0, 4'h1, ok);
      wr(rsw_pkg::ADDR_KEY, {24'h0, keys[i]}, 4'h1, ok);
      rd(rsw_pkg::ADDR_STATUS, 32'h1000000, {7'h0, keys[i] != 8'h55, 24'h0}, ok);
      c0 = last[21:0];
      repeat (240) @(posedge mclk_in);
      rd(rsw_pkg::ADDR_STATUS, 32'h0, 32'h0, ok);
      c1 = last[21:0] - c0;
      chk(32'((keys[i] == 8'h55) ? (c1 == 22'h0) : (c1 inside {[20:21]})), 32'h1);
    end
    wr(rsw_pkg::ADDR_KEY, 32'h55, 4'h0, ok);
    rd(rsw_pkg::ADDR_KEY, 32'hff, 32'h54, ok);
    wr(rsw_pkg::ADDR_KEY, 32'h55, 4'h1, ok);
    // pin reset clears key and counter
    @(posedge mclk_in);
    ext_n <= 1'b0;
    @(posedge mclk_in);
    stay(1'b1, 30);
    // held well past two machine cycles
    @(posedge mclk_in);
    ext_n <= 1'b1;
    stay(1'b1, 8);
    turn(1'b0, 40);
    rd(rsw_pkg::ADDR_KEY, 32'hff, 32'h0, ok);
    rd(rsw_pkg::ADDR_STATUS, 32'h13fffe0, 32'h1000000, ok);
    // low supply lingers after recovery
    @(posedge mclk_in);
    low <= 1'b1;
    turn(1'b1, 4);
    @(posedge mclk_in);
    low <= 1'b0;
    stay(1'b1, 20);
    turn(1'b0, 60);
    wr(rsw_pkg::ADDR_PWR_CTRL, 32'h0, 4'h1, ok);
    rd(rsw_pkg::ADDR_PWR_CTRL, 32'hff, 32'h0, ok);
    low <= 1'b1;
    stay(1'b0, 12);
    @(posedge mclk_in);
    low <= 1'b0;
    wr(rsw_pkg::ADDR_PWR_CTRL, 32'h1, 4'h1, ok);
    // short se0 is no bus reset
    se0 <= 1'b1;
    repeat (24) @(posedge mclk_in);
    se0 <= 1'b0;
    rd(rsw_pkg::ADDR_USB_STA, 32'h40, 32'h0, ok);
    se0 <= 1'b1;
    stay(1'b0, 100);
    @(posedge mclk_in);
    se0 <= 1'b0;
    rd(rsw_pkg::ADDR_USB_STA, 32'h40, 32'h40, ok);
    wr(rsw_pkg::ADDR_USB_STA, 32'h40, 4'h1, ok);
    rd(rsw_pkg::ADDR_USB_STA, 32'h40, 32'h0, ok);
    wr(rsw_pkg::ADDR_USB_EN, 32'h40, 4'h1, ok);
    se0 <= 1'b1;
    turn(1'b1, 72);
    @(posedge mclk_in);
    se0 <= 1'b0;
    turn(1'b0, 60);
    // unmapped and read-only places
    rd(12'h100, 32'hffffffff, 32'h0, err);
    wr(12'h100, 32'h1, 4'h1, err);
    wr(rsw_pkg::ADDR_STATUS, 32'h0, 4'h1, ok);
    end_of_test();
  end
endmodule : tb_top
bind rsw_top rsw_assertions u_chk (.mclk_in(mclk_in), .srst_in(srst_in), .awvalid_in(awvalid_in),
  .awready_out(awready_out), .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out),
  .bvalid_out(bvalid_out), .bready_in(bready_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .rready_in(rready_in), .ext_reset_n_in(ext_reset_n_in),
  .core_reset_out(core_reset_out), .mem_reset_n_out(mem_reset_n_out));
